// *** logic/cwcfg_regs.sv ***
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cwcfg_consts.svh"
// Behaviour
// - hpf enable bit switches filter on
// - feedback field picks filter resistance
// - filter off ignores field, path open
// - clock field decodes 16X 8X 4X 1X
// - amp disable bit effective only in doppler
// - path bit selects imaging or doppler
// - base buffer: 0 cmos, 1 differential
// - fast buffer: 0 differential, 1 cmos
// - gain code selects amp feedback resistor
// - phase code N gives N times 22.5
// - four phase fields for channels one-eight
// - offset bit limits write to even
module cwcfg_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output cwcfg_pkg::cwcfg_ctrl_s ctrl
);
  // *******************************************
  // state
  // *******************************************
  typedef struct packed {
    logic [15:0] config_word; // path configuration
    logic [15:0] phase_word; // mixer phase fields
    logic [15:0] phase_odd; // odd-channel phases kept apart
    logic channel_offset; // pair or even only
    logic aw_held; // address taken, waiting for data
    logic [11:0] aw_addr;
    logic w_held; // data taken, waiting for address
    logic [31:0] w_data;
    logic [3:0] w_strb;
    cwcfg_pkg::cwcfg_wr_e wr_state;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cwcfg_state_s;

  cwcfg_state_s st_q, st_d;

  // register index from a byte address; unaligned bits ignored
  function automatic logic [9:0] reg_index(input logic [11:0] addr);
    reg_index = addr[11:2];
  endfunction : reg_index

  // merge byte strobes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) merge16[7:0] = data[7:0];
    if (strb[1]) merge16[15:8] = data[15:8];
  endfunction : merge16

  // *******************************************
  // bus handshakes, combinational
  // *******************************************
  assign s_axi_awready = ~st_q.aw_held &&
    st_q.wr_state == cwcfg_pkg::CWCFG_W_IDLE;
  assign s_axi_wready = ~st_q.w_held &&
    st_q.wr_state == cwcfg_pkg::CWCFG_W_IDLE;
  assign s_axi_bvalid = st_q.wr_state == cwcfg_pkg::CWCFG_W_RESP;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = ~st_q.rvalid; // one read at a time
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // *******************************************
  // next state
  // *******************************************
  always_comb begin
    logic aw_now;
    logic w_now;
    logic [11:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic [15:0] new_phase;
    aw_now = 1'b0;
    w_now = 1'b0;
    waddr = '0;
    wdat = '0;
    wstb = '0;
    new_phase = '0;
    st_d = st_q;
    // catch address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    aw_now = st_d.aw_held;
    w_now = st_d.w_held;
    waddr = st_d.aw_addr;
    wdat = st_d.w_data;
    wstb = st_d.w_strb;
    // perform the write once both halves are in
    if (aw_now && w_now && st_q.wr_state == cwcfg_pkg::CWCFG_W_IDLE) begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.wr_state = cwcfg_pkg::CWCFG_W_RESP;
      st_d.bresp = `CWCFG_RESP_OKAY;
      unique case (reg_index(waddr))
        10'(`CWCFG_IDX_CONFIG): begin
          // reserved bits stored as plain bits
          st_d.config_word = merge16(st_q.config_word, wdat, wstb);
        end
        10'(`CWCFG_IDX_PHASE): begin
          new_phase = merge16(st_q.phase_word, wdat, wstb);
          st_d.phase_word = new_phase;
          // odd channels only follow while pairs are addressed
          if (!st_q.channel_offset) begin
            st_d.phase_odd = new_phase;
          end
        end
        10'(`CWCFG_IDX_OFFSET): begin
          if (wstb[0]) st_d.channel_offset = wdat[0];
        end
        default: begin
          st_d.bresp = `CWCFG_RESP_SLVERR; // unmapped
        end
      endcase
    end
    // response held until master takes it
    if (st_q.wr_state == cwcfg_pkg::CWCFG_W_RESP && s_axi_bready) begin
      st_d.wr_state = cwcfg_pkg::CWCFG_W_IDLE;
    end
    // read path: answer the cycle after the address
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = `CWCFG_RESP_OKAY;
      unique case (reg_index(s_axi_araddr))
        10'(`CWCFG_IDX_CONFIG): st_d.rdata = {16'h0000, st_q.config_word};
        10'(`CWCFG_IDX_PHASE): st_d.rdata = {16'h0000, st_q.phase_word};
        10'(`CWCFG_IDX_OFFSET): st_d.rdata = {31'h0, st_q.channel_offset};
        // status shows the odd-channel phases actually in force
        10'(`CWCFG_IDX_STATUS): st_d.rdata = {16'h0000, st_q.phase_odd};
        default: begin
          st_d.rdata = 32'h00000000;
          st_d.rresp = `CWCFG_RESP_SLVERR;
        end
      endcase
    end
  end

  // *******************************************
  // registers
  // *******************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.config_word <= `CWCFG_RST_CONFIG;
      st_q.phase_word <= `CWCFG_RST_PHASE;
      st_q.phase_odd <= `CWCFG_RST_PHASE;
      st_q.channel_offset <= `CWCFG_RST_OFFSET;
      st_q.wr_state <= cwcfg_pkg::CWCFG_W_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // *******************************************
  // analog control decode
  // *******************************************
  cwcfg_pkg::cwcfg_ctrl_s dec;
  cwcfg_decode u_decode (
    .config_word(st_q.config_word),
    .phase_word(st_q.phase_word),
    .channel_offset(st_q.channel_offset),
    .ctrl(dec)
  );

  // odd channels take their kept copy
  always_comb begin
    ctrl = dec;
    for (int p = 0; p < 4; p++) begin
      ctrl.mixer_phase[2*p] = st_q.phase_odd[4*p +: 4];
    end
  end
endmodule : cwcfg_regs
`default_nettype wire

// *** logic/cwcfg_consts.svh ***
`ifndef CWCFG_CONSTS_SVH
`define CWCFG_CONSTS_SVH
// register indices as printed; byte address is four times the index
`define CWCFG_IDX_CONFIG 8'hC6
`define CWCFG_IDX_PHASE 8'hC7
`define CWCFG_IDX_OFFSET 8'hD0
`define CWCFG_IDX_STATUS 8'hD1
`define CWCFG_ADDR_W 12
`define CWCFG_RST_CONFIG 16'h0000
`define CWCFG_RST_PHASE 16'h0000
`define CWCFG_RST_OFFSET 1'b0
// field positions of the config register
`define CWCFG_BIT_HPF_EN 14
`define CWCFG_FB_HI 13
`define CWCFG_FB_LO 12
`define CWCFG_CLK_HI 11
`define CWCFG_CLK_LO 10
`define CWCFG_BIT_AMP_DIS 9
`define CWCFG_BIT_PATH 8
`define CWCFG_BIT_BASE_BUF 6
`define CWCFG_BIT_FAST_BUF 5
`define CWCFG_GAIN_HI 4
`define CWCFG_GAIN_LO 0
// axi response codes
`define CWCFG_RESP_OKAY 2'h0
`define CWCFG_RESP_SLVERR 2'h2
`endif

// *** logic/cwcfg_pkg.sv ***
`default_nettype none
package cwcfg_pkg;
  // clock multiplier decode
  typedef enum logic [1:0] {
    CWCFG_CLK_16X = 2'b00,
    CWCFG_CLK_8X = 2'b01,
    CWCFG_CLK_4X = 2'b10,
    CWCFG_CLK_1X = 2'b11
  } cwcfg_clk_e;
  // write channel state
  typedef enum logic [1:0] {
    CWCFG_W_IDLE = 2'b00,
    CWCFG_W_RESP = 2'b01
  } cwcfg_wr_e;
  // decoded analog controls
  typedef struct packed {
    logic doppler_path;
    logic summing_amp_on;
    logic hpf_enable;
    logic [3:0] hpf_feedback_onehot;
    cwcfg_clk_e doppler_clock_multiplier;
    logic base_clock_buffer_diff;
    logic fast_clock_buffer_diff;
    logic [4:0] summing_amp_feedback_code;
    logic [4:0] summing_amp_taps;
    logic [7:0][3:0] mixer_phase; // packed so the struct stays packed
  } cwcfg_ctrl_s;
endpackage : cwcfg_pkg
`default_nettype wire

// *** logic/cwcfg_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cwcfg_consts.svh"
// turns the two stored words into analog control levels
module cwcfg_decode (
  input wire logic [15:0] config_word,
  input wire logic [15:0] phase_word,
  input wire logic channel_offset,
  output cwcfg_pkg::cwcfg_ctrl_s ctrl
);
  // *******************************************
  // fixed feedback-resistor tap table
  // *******************************************
  // code to tap word; tap bits 4..0 weigh 2000/1000/500/250/500 ohm legs
  function automatic logic [4:0] fb_taps(input logic [4:0] code);
    fb_taps = code; // legs follow the code bits; 0 leaves all legs open
  endfunction : fb_taps

  always_comb begin
    ctrl = '0;
    // path select: doppler path does not power attenuator down
    ctrl.doppler_path = config_word[`CWCFG_BIT_PATH];
    // amp disable honoured only on doppler path
    ctrl.summing_amp_on = config_word[`CWCFG_BIT_PATH] &
      ~config_word[`CWCFG_BIT_AMP_DIS];
    ctrl.hpf_enable = config_word[`CWCFG_BIT_HPF_EN];
    // feedback one-hot only while filter on, else path open
    if (config_word[`CWCFG_BIT_HPF_EN]) begin
      ctrl.hpf_feedback_onehot = 4'h1 <<
        config_word[`CWCFG_FB_HI:`CWCFG_FB_LO];
    end else begin
      ctrl.hpf_feedback_onehot = 4'h0;
    end
    ctrl.doppler_clock_multiplier = cwcfg_pkg::cwcfg_clk_e'(
      config_word[`CWCFG_CLK_HI:`CWCFG_CLK_LO]);
    ctrl.base_clock_buffer_diff = config_word[`CWCFG_BIT_BASE_BUF];
    // fast buffer has reversed polarity
    ctrl.fast_clock_buffer_diff = ~config_word[`CWCFG_BIT_FAST_BUF];
    ctrl.summing_amp_feedback_code =
      config_word[`CWCFG_GAIN_HI:`CWCFG_GAIN_LO];
    ctrl.summing_amp_taps =
      fb_taps(config_word[`CWCFG_GAIN_HI:`CWCFG_GAIN_LO]);
    // pair fields: odd channel follows unless offset set
    for (int p = 0; p < 4; p++) begin
      ctrl.mixer_phase[2*p+1] = phase_word[4*p +: 4];
      ctrl.mixer_phase[2*p] = channel_offset ? 4'h0 : phase_word[4*p +: 4];
    end
  end
endmodule : cwcfg_decode
`default_nettype wire

// *** bench/cwcfg_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cwcfg_consts.svh"
// ****************
// bus and decode watcher
// ****************
module cwcfg_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire cwcfg_pkg::cwcfg_ctrl_s ctrl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] addr_q; // address of the read in flight
  logic ok_q; // read answer is a plain okay
  // remember the read address so the answer can be matched to its register
  always_ff @(posedge aclk) begin
    if (!aresetn) addr_q <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready) addr_q <= s_axi_araddr;
  end
  assign ok_q = s_axi_rvalid && (s_axi_rresp == `CWCFG_RESP_OKAY);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence cfg_seen;
    ok_q && addr_q == 12'h318;
  endsequence
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  hpf_open_a: assert property (!ctrl.hpf_enable |-> ctrl.hpf_feedback_onehot == 4'h0)
    else $error("feedback closed while filter off");
  hpf_pick_a: assert property (cfg_seen |-> ctrl.hpf_feedback_onehot ==
    (s_axi_rdata[14] ? 4'h1 << s_axi_rdata[13:12] : 4'h0)) else $error("filter decode");
  cfg_view_a: assert property (cfg_seen |-> ctrl.doppler_path == s_axi_rdata[8]
    && ctrl.doppler_clock_multiplier == s_axi_rdata[11:10]
    && ctrl.base_clock_buffer_diff == s_axi_rdata[6]
    && ctrl.fast_clock_buffer_diff != s_axi_rdata[5]) else $error("config decode");
  amp_gate_a: assert property (cfg_seen |-> ctrl.summing_amp_feedback_code ==
    s_axi_rdata[4:0] && ctrl.summing_amp_on == (s_axi_rdata[8] && !s_axi_rdata[9]))
    else $error("amplifier decode");
  ph_view_a: assert property (ok_q && addr_q == 12'h31C |->
    s_axi_rdata[15:12] == ctrl.mixer_phase[7] && s_axi_rdata[3:0] == ctrl.mixer_phase[1])
    else $error("phase field placement");
  bad_zero_a: assert property (s_axi_rvalid && s_axi_rresp != `CWCFG_RESP_OKAY
    |-> s_axi_rdata == 32'h00000000) else $error("refused read not zero");
endmodule : cwcfg_checker
bind cwcfg_regs cwcfg_checker chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .ctrl(ctrl));
`default_nettype wire

// *** bench/cwcfg_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cwcfg_consts.svh"
module cwcfg_regs_test;
  // ****************
  // stimulus and bus tasks
  // ****************
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  cwcfg_pkg::cwcfg_ctrl_s ctrl;
  int fail_count = 0, num_checks = 0;
  always #2 aclk = ~aclk; // 250 MHz
  cwcfg_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ctrl(ctrl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
    end
  endtask : chk_resp
  // address and data offered together, each dropped once taken
  // handshakes are judged on settled values at the falling edge, which
  // equal what the design samples at the following rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_t, w_t, b_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    b_t = 1'b0;
    r = 2'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar_t, r_t;
    ar_t = 1'b0;
    r_t = 1'b0;
    d = 32'h00000000;
    r = 2'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // six config patterns, upper half written with ones that must read 0
  task automatic t_cfg();
    logic [15:0] cv [6] = '{16'h0000, 16'h5561, 16'h2A90, 16'h7F5F, 16'h4300, 16'h4100};
    logic [31:0] d;
    logic [1:0] r;
    foreach (cv[i]) begin
      wr(12'h318, {16'hFFFF, cv[i]}, r);
      rd(12'h318, d, r);
      chk(d, {16'h0000, cv[i]});
      chk({ctrl.hpf_enable, ctrl.hpf_feedback_onehot, 2'(ctrl.doppler_clock_multiplier),
        ctrl.summing_amp_on, ctrl.doppler_path, ctrl.base_clock_buffer_diff,
        ctrl.fast_clock_buffer_diff, ctrl.summing_amp_feedback_code},
        {cv[i][14], cv[i][14] ? 4'h1 << cv[i][13:12] : 4'h0, cv[i][11:10],
        cv[i][8] & ~cv[i][9], cv[i][8], cv[i][6], ~cv[i][5], cv[i][4:0]});
    end
  endtask : t_cfg
  // pair writes, then even-only writes leave odd channels alone
  task automatic t_phase();
    logic [31:0] d;
    logic [1:0] r;
    rd(12'h31C, d, r);
    chk(d, 32'h00000000);
    wr(12'h340, 32'h00000000, r);
    wr(12'h31C, 32'h00004321, r);
    for (int k = 0; k < 8; k++) chk(ctrl.mixer_phase[k], k / 2 + 1);
    wr(12'h340, 32'h00000001, r);
    wr(12'h31C, 32'h00008765, r);
    rd(12'h31C, d, r);
    chk(d, 32'h00008765);
    for (int k = 0; k < 8; k++) chk(ctrl.mixer_phase[k], k / 2 + 1 + (k % 2) * 4);
    rd(12'h344, d, r);
    chk(d, 32'h00004321);
    rd(12'h340, d, r);
    chk(d, 32'h00000001);
  endtask : t_phase
  task automatic t_err();
    logic [31:0] d;
    logic [1:0] r;
    wr(12'h400, 32'h0000FFFF, r);
    chk_resp(r, `CWCFG_RESP_SLVERR);
    rd(12'h400, d, r);
    chk_resp(r, `CWCFG_RESP_SLVERR);
    chk(d, 32'h00000000);
  endtask : t_err
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_phase();
    t_cfg();
    t_err();
    end_sim();
  end
endmodule : cwcfg_regs_test
`default_nettype wire
